// >>> verilog/hpmc_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - Config byte three bit 3 selects renumbering
// - Config byte three bit 0 enables strings
// - Fixed device byte flags non-removable ports
// - Report attached fixed ports to host
// - Fixed device straps apply in default mode
// - Bits 2 and 1 map ports 2, 1
// - Self-powered mask disables ports when set
// - Bus-powered mask disables ports when set
// - Disabled ports never enabled without renumbering
// - Report enabled count, renumber active ports
// - Either port-off strap of a pair disables its port by default
// - Strapped fixed port reports compound device
module hpmc_regs
	import hpmc_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SELF_POWERED,
	input  wire logic [1:0]  FIXED_DEVICE_STRAP,
	input  wire logic [2:1]  PORT_OFF_STRAP_PLUS,
	input  wire logic [2:1]  PORT_OFF_STRAP_MINUS,
	output logic             STRING_ENABLE,
	output logic             PORT_RENUMBER_ENABLE,
	output logic [2:1]       PORT_ACTIVE,
	output logic [2:1]       PORT_FIXED_REPORTED,
	output logic [1:0]       PORT_COUNT,
	output logic [2:1]       LOGICAL_PORT1_PHYS,
	output logic             COMPOUND_DEVICE
);

	hpmc_state_t state_q;
	logic [7:0]  cfg3_q;
	logic [7:0]  fixed_q;
	logic [7:0]  sp_off_q;
	logic [7:0]  bp_off_q;
	logic        use_strap_q;
	logic [7:0]  strap_fixed_q;
	logic [7:0]  strap_off_q;
	logic        strap_taken_q;
	logic [31:0] prdata_d;
	logic        known;
	logic        wr_now;
	logic [7:0]  eff_fixed;
	logic [7:0]  eff_off;
	logic [2:1]  active_d;
	logic [2:1]  fixed_d;
	logic [1:0]  count_d;
	logic [2:1]  phys1_d;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == HPMC_OFS_CFG3) || (a == HPMC_OFS_FIXED) ||
			(a == HPMC_OFS_SP_OFF) || (a == HPMC_OFS_BP_OFF) ||
			(a == HPMC_OFS_CTRL) || (a == HPMC_OFS_STATUS);
	endfunction : addr_known

	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction : byte_addr

	// Indexed registers sit at four times their index
	function automatic logic [7:0] map_addr(input logic [7:0] a);
		if (a == byte_addr(HPMC_IDX_CFG3)) begin
			map_addr = HPMC_OFS_CFG3;
		end else if (a == byte_addr(HPMC_IDX_FIXED)) begin
			map_addr = HPMC_OFS_FIXED;
		end else if (a == byte_addr(HPMC_IDX_SP_OFF)) begin
			map_addr = HPMC_OFS_SP_OFF;
		end else if (a == byte_addr(HPMC_IDX_BP_OFF)) begin
			map_addr = HPMC_OFS_BP_OFF;
		end else if (a == HPMC_OFS_CTRL) begin
			map_addr = HPMC_OFS_CTRL;
		end else if (a == HPMC_OFS_STATUS) begin
			map_addr = HPMC_OFS_STATUS;
		end else begin
			map_addr = 8'hFF;
		end
	endfunction : map_addr

	logic [7:0] reg_sel;
	assign reg_sel = map_addr(PADDR);
	assign known   = addr_known(reg_sel);
	assign wr_now  = PSEL && PENABLE && PWRITE && known &&
		state_q == HPMC_ACCESS;

	// APB phase tracking
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_q <= HPMC_IDLE;
		end else if (PSEL && !PENABLE) begin
			state_q <= HPMC_ACCESS;
		end else begin
			state_q <= HPMC_IDLE;
		end
	end

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !known;

	// Config byte three
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			cfg3_q <= HPMC_RST_CFG3;
		end else if (wr_now && reg_sel == HPMC_OFS_CFG3) begin
			cfg3_q <= PWDATA[7:0] & HPMC_MASK_CFG3;
		end
	end

	// Port flag bytes
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fixed_q  <= HPMC_RST_PORTS;
			sp_off_q <= HPMC_RST_PORTS;
			bp_off_q <= HPMC_RST_PORTS;
		end else if (wr_now) begin
			if (reg_sel == HPMC_OFS_FIXED) begin
				fixed_q <= PWDATA[7:0] & HPMC_MASK_PORTS;
			end else if (reg_sel == HPMC_OFS_SP_OFF) begin
				sp_off_q <= PWDATA[7:0] & HPMC_MASK_PORTS;
			end else if (reg_sel == HPMC_OFS_BP_OFF) begin
				bp_off_q <= PWDATA[7:0] & HPMC_MASK_PORTS;
			end
		end
	end

	// Source select: straps or registers
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			use_strap_q <= HPMC_RST_USE_STRAP;
		end else if (wr_now && reg_sel == HPMC_OFS_CTRL) begin
			use_strap_q <= PWDATA[HPMC_BIT_USE_STRAP];
		end
	end

	// Straps caught on first clock after reset release
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			strap_taken_q <= 1'b0;
			strap_fixed_q <= HPMC_RST_PORTS;
			strap_off_q   <= HPMC_RST_PORTS;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			strap_fixed_q <= {5'h00, FIXED_DEVICE_STRAP, 1'b0};
			strap_off_q   <= {5'h00,
				PORT_OFF_STRAP_PLUS | PORT_OFF_STRAP_MINUS, 1'b0};
		end
	end

	always_comb begin
		eff_fixed = use_strap_q ? strap_fixed_q : fixed_q;
		if (use_strap_q) begin
			eff_off = strap_off_q;
		end else if (SELF_POWERED) begin
			eff_off = sp_off_q;
		end else begin
			eff_off = bp_off_q;
		end
		// Disabled ports stay off whatever the renumber bit; map to host built from active ports
		active_d = ~eff_off[HPMC_BIT_PORT2:HPMC_BIT_PORT1];
		fixed_d  = eff_fixed[HPMC_BIT_PORT2:HPMC_BIT_PORT1] & active_d;
		count_d  = {1'b0, active_d[1]} + {1'b0, active_d[2]};
		// Logical port 1 is lowest active physical port
		if (active_d[1]) begin
			phys1_d = 2'b01;
		end else if (active_d[2]) begin
			phys1_d = 2'b10;
		end else begin
			phys1_d = 2'b00;
		end
	end

	// Host-facing outputs
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PORT_ACTIVE         <= 2'b00;
			PORT_FIXED_REPORTED <= 2'b00;
			PORT_COUNT          <= 2'b00;
			LOGICAL_PORT1_PHYS  <= 2'b00;
			COMPOUND_DEVICE     <= 1'b0;
			STRING_ENABLE       <= 1'b0;
			PORT_RENUMBER_ENABLE <= 1'b0;
		end else begin
			PORT_ACTIVE         <= active_d;
			PORT_FIXED_REPORTED <= fixed_d;
			PORT_COUNT          <= count_d;
			LOGICAL_PORT1_PHYS  <= phys1_d;
			COMPOUND_DEVICE     <= use_strap_q && (|fixed_d);
			STRING_ENABLE       <= cfg3_q[HPMC_BIT_STRING];
			PORT_RENUMBER_ENABLE <= cfg3_q[HPMC_BIT_RENUMBER];
		end
	end

	// Read mux
	always_comb begin
		prdata_d = 32'h0000_0000;
		if (reg_sel == HPMC_OFS_CFG3) begin
			prdata_d = {24'h00_0000, cfg3_q};
		end else if (reg_sel == HPMC_OFS_FIXED) begin
			prdata_d = {24'h00_0000, fixed_q};
		end else if (reg_sel == HPMC_OFS_SP_OFF) begin
			prdata_d = {24'h00_0000, sp_off_q};
		end else if (reg_sel == HPMC_OFS_BP_OFF) begin
			prdata_d = {24'h00_0000, bp_off_q};
		end else if (reg_sel == HPMC_OFS_CTRL) begin
			prdata_d = {31'h0000_0000, use_strap_q};
		end else if (reg_sel == HPMC_OFS_STATUS) begin
			prdata_d = {23'h00_0000, COMPOUND_DEVICE, PORT_COUNT,
				PORT_FIXED_REPORTED, PORT_ACTIVE, LOGICAL_PORT1_PHYS};
		end
	end

	// Read data registered in setup cycle
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= prdata_d;
		end
	end

	// Register write steps and a register-mode fixed port 2 condition shared by the checks below
	sequence s_cfg3_write;
		wr_now && reg_sel == HPMC_OFS_CFG3;
	endsequence

	sequence s_fixed_write;
		wr_now && reg_sel == HPMC_OFS_FIXED;
	endsequence

	sequence s_reg_fixed2;
		!use_strap_q && fixed_q[HPMC_BIT_PORT2] && !eff_off[HPMC_BIT_PORT2];
	endsequence

	a_cfg_write_mask: assert property (
		@(posedge CLOCK) disable iff (RST)
		s_cfg3_write |=> cfg3_q[7:4] == 4'h0 && cfg3_q[2:1] == 2'b00)
		else $error("reserved config bits stored");

	a_string_follow: assert property (
		@(posedge CLOCK) disable iff (RST)
		##1 STRING_ENABLE == $past(cfg3_q[HPMC_BIT_STRING]))
		else $error("string enable wrong");

	a_string_write: assert property (
		@(posedge CLOCK) disable iff (RST)
		s_cfg3_write ##1 1'b1
		|=> STRING_ENABLE == $past(PWDATA[HPMC_BIT_STRING], 2))
		else $error("string enable not written");

	a_renum_follow: assert property (
		@(posedge CLOCK) disable iff (RST)
		##1 PORT_RENUMBER_ENABLE == $past(cfg3_q[HPMC_BIT_RENUMBER]))
		else $error("renumber enable wrong");

	a_sp_disable: assert property (
		@(posedge CLOCK) disable iff (RST)
		!use_strap_q && SELF_POWERED && sp_off_q[HPMC_BIT_PORT1]
		|=> !PORT_ACTIVE[1])
		else $error("self powered disable ignored");

	a_bp_disable: assert property (
		@(posedge CLOCK) disable iff (RST)
		!use_strap_q && !SELF_POWERED && bp_off_q[HPMC_BIT_PORT2]
		|=> !PORT_ACTIVE[2])
		else $error("bus powered disable ignored");

	a_port_count: assert property (
		@(posedge CLOCK) disable iff (RST)
		##1 PORT_COUNT == {1'b0, PORT_ACTIVE[1]}
		+ {1'b0, PORT_ACTIVE[2]})
		else $error("port count mismatch");

	a_fixed_active: assert property (
		@(posedge CLOCK) disable iff (RST)
		(PORT_FIXED_REPORTED & ~PORT_ACTIVE) == 2'b00)
		else $error("fixed port not active");

	a_compound_strap: assert property (
		@(posedge CLOCK) disable iff (RST)
		COMPOUND_DEVICE |-> $past(use_strap_q))
		else $error("compound without straps");

	a_port_mask: assert property (
		@(posedge CLOCK) disable iff (RST)
		((fixed_q | sp_off_q | bp_off_q) & ~HPMC_MASK_PORTS) == 8'h00)
		else $error("reserved port bit set");

	a_strap_off: assert property (
		@(posedge CLOCK) disable iff (RST)
		strap_taken_q && use_strap_q && strap_off_q[HPMC_BIT_PORT2]
		|=> !PORT_ACTIVE[2])
		else $error("strap disable ignored");

	a_strap_fixed: assert property (
		@(posedge CLOCK) disable iff (RST)
		use_strap_q && strap_fixed_q[HPMC_BIT_PORT1]
		&& !strap_off_q[HPMC_BIT_PORT1] |=> PORT_FIXED_REPORTED[1])
		else $error("strap fixed ignored");

	a_straps_held: assert property (
		@(posedge CLOCK) disable iff (RST)
		strap_taken_q |=> $stable(strap_fixed_q) && $stable(strap_off_q))
		else $error("strap capture changed");

	a_fixed_reg: assert property (
		@(posedge CLOCK) disable iff (RST)
		s_reg_fixed2 |=> PORT_FIXED_REPORTED[2])
		else $error("fixed flag lost");

	a_fixed_write: assert property (
		@(posedge CLOCK) disable iff (RST)
		s_fixed_write
		|=> fixed_q == ($past(PWDATA[7:0]) & HPMC_MASK_PORTS))
		else $error("fixed byte not written");

	a_off_stays: assert property (
		@(posedge CLOCK) disable iff (RST)
		!use_strap_q && SELF_POWERED && sp_off_q[HPMC_BIT_PORT2]
		&& !cfg3_q[HPMC_BIT_RENUMBER] |=> !PORT_ACTIVE[2])
		else $error("disabled port enabled");

	a_unmapped_write: assert property (
		@(posedge CLOCK) disable iff (RST)
		PSEL && PENABLE && PWRITE && !known |=> $stable(cfg3_q)
		&& $stable(fixed_q) && $stable(sp_off_q) && $stable(bp_off_q)
		&& $stable(use_strap_q))
		else $error("unmapped write stored");

	a_read_upper: assert property (
		@(posedge CLOCK) disable iff (RST)
		PSEL && PENABLE && !PWRITE |-> PRDATA[31:9] == 23'h00_0000)
		else $error("upper read bits set");

	a_phys_active: assert property (
		@(posedge CLOCK) disable iff (RST)
		(LOGICAL_PORT1_PHYS & ~PORT_ACTIVE) == 2'b00)
		else $error("logical port one not active");

	a_phys_none: assert property (
		@(posedge CLOCK) disable iff (RST)
		(PORT_COUNT == 2'b00) == (LOGICAL_PORT1_PHYS == 2'b00))
		else $error("logical port one without ports");

endmodule : hpmc_regs

// >>> common/hpmc_pkg.sv
package hpmc_pkg;

	// Internal register selects; only CTRL and STATUS are also byte addresses on the APB bus
	localparam logic [7:0] HPMC_OFS_CFG3    = 8'h08;
	localparam logic [7:0] HPMC_OFS_FIXED   = 8'h09;
	localparam logic [7:0] HPMC_OFS_SP_OFF  = 8'h0A;
	localparam logic [7:0] HPMC_OFS_BP_OFF  = 8'h0B;
	localparam logic [7:0] HPMC_OFS_CTRL    = 8'h0C;
	localparam logic [7:0] HPMC_OFS_STATUS  = 8'h10;

	// Register indices: byte address is index times four
	localparam logic [7:0] HPMC_IDX_CFG3    = 8'h08;
	localparam logic [7:0] HPMC_IDX_FIXED   = 8'h09;
	localparam logic [7:0] HPMC_IDX_SP_OFF  = 8'h0A;
	localparam logic [7:0] HPMC_IDX_BP_OFF  = 8'h0B;

	// Field positions
	localparam int HPMC_BIT_STRING   = 0;
	localparam int HPMC_BIT_RENUMBER = 3;
	localparam int HPMC_BIT_PORT1    = 1;
	localparam int HPMC_BIT_PORT2    = 2;
	localparam int HPMC_BIT_USE_STRAP = 0;

	// Writable masks
	localparam logic [7:0] HPMC_MASK_CFG3  = 8'h09;
	localparam logic [7:0] HPMC_MASK_PORTS = 8'h06;

	// Reset values
	localparam logic [7:0] HPMC_RST_CFG3  = 8'h00;
	localparam logic [7:0] HPMC_RST_PORTS = 8'h00;
	localparam logic       HPMC_RST_USE_STRAP = 1'b1;

	typedef enum logic [1:0] {
		HPMC_IDLE,
		HPMC_ACCESS
	} hpmc_state_t;

endpackage : hpmc_pkg

// >>> tb/hpmc_apb_host.sv
`timescale 1ns/10ps
module hpmc_apb_host (
	input  wire logic        CLOCK,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR,
	input  wire logic [31:0] PRDATA,
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic      [7:0]  PADDR,
	output logic      [31:0] PWDATA
);
	logic hung = 1'b0;
	initial begin
		PSEL    = 1'b0;
		PENABLE = 1'b0;
		PWRITE  = 1'b0;
		PADDR   = 8'h00;
		PWDATA  = 32'h0000_0000;
	end
	// One transfer; address and write data inverted on release so stale data is not seen
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge CLOCK);
		PSEL   <= 1'b1;
		PWRITE <= w;
		PADDR  <= a;
		PWDATA <= wd;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		hung = (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		PADDR   <= ~a;
		PWDATA  <= ~wd;
	endtask : xfer
endmodule : hpmc_apb_host

// >>> tb/hpmc_regs_bench.sv
`timescale 1ns/10ps
module hpmc_regs_bench
	import hpmc_pkg::*;
;
	logic        CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic        SELF_POWERED, STRING_ENABLE, PORT_RENUMBER_ENABLE;
	logic [1:0]  FIXED_DEVICE_STRAP, PORT_COUNT;
	logic [2:1]  PORT_OFF_STRAP_PLUS, PORT_OFF_STRAP_MINUS, PORT_ACTIVE;
	logic [2:1]  PORT_FIXED_REPORTED, LOGICAL_PORT1_PHYS;
	logic        COMPOUND_DEVICE;
	int          miscompares = 0;
	int          compares = 0;
	logic [31:0] seed = 32'h62f2_23fd;
	logic [7:0]  adr [5] = '{8'(HPMC_IDX_CFG3 * 4), 8'(HPMC_IDX_FIXED * 4),
		8'(HPMC_IDX_SP_OFF * 4), 8'(HPMC_IDX_BP_OFF * 4), HPMC_OFS_CTRL};
	int          msk [5] = '{9, 6, 6, 6, 1};
	int          mdl [5] = '{0, 0, 0, 0, 1};

	hpmc_regs hpmc_regs_i (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SELF_POWERED(SELF_POWERED), .FIXED_DEVICE_STRAP(FIXED_DEVICE_STRAP),
		.PORT_OFF_STRAP_PLUS(PORT_OFF_STRAP_PLUS),
		.PORT_OFF_STRAP_MINUS(PORT_OFF_STRAP_MINUS),
		.STRING_ENABLE(STRING_ENABLE),
		.PORT_RENUMBER_ENABLE(PORT_RENUMBER_ENABLE),
		.PORT_ACTIVE(PORT_ACTIVE), .PORT_FIXED_REPORTED(PORT_FIXED_REPORTED),
		.PORT_COUNT(PORT_COUNT), .LOGICAL_PORT1_PHYS(LOGICAL_PORT1_PHYS),
		.COMPOUND_DEVICE(COMPOUND_DEVICE));
	hpmc_apb_host hpmc_apb_host_i (.CLOCK(CLOCK), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PRDATA(PRDATA), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Status word predicted from model registers and strap pins
	function automatic int exp_status();
		int fx, off, act, cnt, l1;
		fx  = mdl[4] ? 2 * int'(FIXED_DEVICE_STRAP) : mdl[1];
		off = mdl[4] ? 2 * int'(PORT_OFF_STRAP_PLUS | PORT_OFF_STRAP_MINUS)
			: (SELF_POWERED ? mdl[2] : mdl[3]);
		act = ~off & 6;
		cnt = ((act >> 1) & 1) + ((act >> 2) & 1);
		l1  = (act & 2) ? 1 : ((act & 4) ? 2 : 0);
		fx  = act & fx;
		return (int'(mdl[4] != 0 && fx != 0) << 8) | (cnt << 6)
			| ((fx >> 1) << 4) | ((act >> 1) << 2) | l1;
	endfunction : exp_status

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] expv);
		compares++;
		if (seen !== expv) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, expv, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task automatic rw(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		hpmc_apb_host_i.xfer(w, a, wd, rd, err);
		if (hpmc_apb_host_i.hung) begin
			miscompares++;
			close_out();
		end
	endtask : rw

	task automatic check_all();
		logic [31:0] r;
		logic        e;
		for (int k = 0; k < 5; k++) begin
			rw(1'b0, adr[k], 32'h0, r, e);
			chk("register", r, 32'(mdl[k]));
			chk("slave error", 32'(e), 32'h0);
		end
		rw(1'b0, HPMC_OFS_STATUS, 32'h0, r, e);
		chk("status", r, 32'(exp_status()));
		repeat (2) @(posedge CLOCK);
		@(negedge CLOCK);
		chk("port outputs", 32'({COMPOUND_DEVICE, PORT_COUNT,
			PORT_FIXED_REPORTED, PORT_ACTIVE, LOGICAL_PORT1_PHYS}),
			32'(exp_status()));
		chk("cfg outputs", 32'({PORT_RENUMBER_ENABLE, STRING_ENABLE}),
			32'({mdl[0][3], mdl[0][0]}));
		@(posedge CLOCK);
	endtask : check_all

	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	initial begin
		logic [31:0] v, r;
		logic        e;
		RST = 1'b1;
		SELF_POWERED = 1'b0;
		FIXED_DEVICE_STRAP = 2'b00;
		PORT_OFF_STRAP_PLUS = 2'b00;
		PORT_OFF_STRAP_MINUS = 2'b00;
		repeat (4) @(posedge CLOCK);
		RST <= 1'b0;
		repeat (3) @(posedge CLOCK);
		check_all();
		$display("Reset value test done");
		for (int i = 0; i < 24; i++) begin
			v = rnd();
			SELF_POWERED <= v[0];
			if (i % 4 == 0) begin
				RST <= 1'b1;
				FIXED_DEVICE_STRAP <= v[2:1];
				PORT_OFF_STRAP_PLUS <= v[4:3];
				PORT_OFF_STRAP_MINUS <= v[6:5];
				repeat (2) @(posedge CLOCK);
				RST <= 1'b0;
				mdl = '{0, 0, 0, 0, 1};
				repeat (3) @(posedge CLOCK);
				check_all();
			end
			for (int k = 0; k < 5; k++) begin
				v = rnd();
				rw(1'b1, adr[k], v, r, e);
				mdl[k] = int'(v[7:0]) & msk[k];
			end
			repeat (3) @(posedge CLOCK);
			check_all();
		end
		$display("Random configuration test done");
		rw(1'b1, 8'h14, 32'hFFFF_FFFF, r, e);
		chk("unmapped write error", 32'(e), 32'h1);
		rw(1'b0, 8'h14, 32'h0, r, e);
		chk("unmapped read data", r, 32'h0);
		chk("unmapped read error", 32'(e), 32'h1);
		check_all();
		$display("Unmapped address test done");
		close_out();
	end
endmodule : hpmc_regs_bench
